// ===== logic/bts_pkg.sv
// Constants for the self-test pattern, PLL alarm, temperature monitor
// and lock-loss alarm register bank.
// Assumes a byte-wide register port from the serial programming logic.
//
// Behaviour
// RULE1: Pattern low byte at 1Dh, bit n is pattern bit n, resets to CCh.
// RULE2: Full 20-bit pattern joins 1Bh nibble, 1Ch byte and this byte.
// RULE3: Bit 7 at 1Fh reads PLL loss of lock, valid only when enabled.
// RULE4: PLL power, reset and lock report depend on transmitter enable bit 1.
// RULE5: Bit 1 at 20h powers the temperature monitor; reset leaves it off.
// RULE6: Rising edge on strobe bit 0 at 20h starts one conversion.
// RULE7: Software writes strobe 1 then 0 for each measurement.
// RULE8: Bits 3:0 at 21h return the result of the latest strobed conversion.
// RULE9: 4-bit temperature code with high and low alarm and warning bands.
// RULE10: Bits 3:0 at 30h hold one latched lock-loss bit per channel.
// RULE11: Global clear empties alarms, then reloads present and new alarms.
// RULE12: A latched lock-loss bit stays set until the next global clear.
package bts_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PATTERN_LOW = 8'h1D;
  localparam logic [7:0] ADDR_TX_ALARM    = 8'h1F;
  localparam logic [7:0] ADDR_TEMP_CTRL   = 8'h20;
  localparam logic [7:0] ADDR_TEMP_VALUE  = 8'h21;
  localparam logic [7:0] ADDR_LOCK_ALARM  = 8'h30;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         TX_UNLOCK_BIT    = 7;
  localparam int         TX_ENABLE_BIT    = 1;
  localparam int         TEMP_EN_BIT      = 1;
  localparam int         TEMP_STROBE_BIT  = 0;
  localparam logic [7:0] RST_PATTERN_LOW  = 8'hCC;
  localparam logic [6:0] RST_TX_ALARM     = 7'h00;
  localparam logic [3:0] RST_TEMP_CTRL    = 4'h0;
  localparam logic [3:0] RST_LOCK_UPPER   = 4'h0;
  localparam logic [3:0] RST_TEMP_CODE    = 4'h0;

  // ----------------------------------------------------------------
  // Temperature codes at band edges
  // ----------------------------------------------------------------
  localparam logic [3:0] TEMP_HIGH_ALARM_MIN = 4'hB;
  localparam logic [3:0] TEMP_HIGH_WARN      = 4'hA;
  localparam logic [3:0] TEMP_LOW_WARN       = 4'h2;
  localparam logic [3:0] TEMP_LOW_ALARM_MAX  = 4'h1;

  // ----------------------------------------------------------------
  // Conversion sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BTS_IDLE = 2'b01,
    BTS_CONV = 2'b10
  } bts_state_t;

endpackage : bts_pkg

// ===== logic/bts_temp_if.sv
// Interface between the register bank and the conversion sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface bts_temp_if;
  logic       enable;  // Monitor powered
  logic       start;   // One-cycle conversion request
  logic       busy;    // Conversion in flight
  logic       valid;   // One-cycle result strobe
  logic [3:0] code;    // Result code

  modport bank (output enable, output start, input busy, input valid, input code);
  modport seq  (input enable, input start, output busy, output valid, output code);
endinterface : bts_temp_if

// ===== logic/bts_temp_seq.sv
// Temperature converter sequencer: drives the converter start and
// power pins and hands back the finished code.
// Assumes the converter raises its done pin for one or more cycles.
`timescale 1ns/100ps
module bts_temp_seq (
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  bts_temp_if.seq         tif,
  output logic            adc_power_o,
  output logic            adc_start_o,
  input  wire logic [3:0] adc_code_i,
  input  wire logic       adc_done_i
);

  bts_pkg::bts_state_t state_q, state_d;
  logic [3:0]          code_q,  code_d;
  logic                valid_q, valid_d;

  // Next state: request starts a conversion, done captures the code
  always_comb begin
    state_d = state_q;
    code_d  = code_q;
    valid_d = 1'b0;
    case (state_q)
      bts_pkg::BTS_IDLE: begin
        if (tif.start && tif.enable) begin // [RULE6]
          state_d = bts_pkg::BTS_CONV;
        end
      end
      bts_pkg::BTS_CONV: begin
        if (!tif.enable) begin // [RULE5]
          state_d = bts_pkg::BTS_IDLE;
        end else if (adc_done_i) begin
          code_d  = adc_code_i;
          valid_d = 1'b1;
          state_d = bts_pkg::BTS_IDLE;
        end
      end
      default: state_d = bts_pkg::BTS_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= bts_pkg::BTS_IDLE;
      code_q  <= bts_pkg::RST_TEMP_CODE;
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      code_q  <= code_d;
      valid_q <= valid_d;
    end
  end

  // Handshake outputs
  assign adc_power_o = tif.enable; // [RULE5]
  assign adc_start_o = (state_q == bts_pkg::BTS_IDLE) && tif.start && tif.enable; // [RULE6]
  assign tif.busy    = (state_q == bts_pkg::BTS_CONV);
  assign tif.valid   = valid_q;
  assign tif.code    = code_q;

  a_start_enters_conv: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RULE6]
    adc_start_o |=> tif.busy)
    else $error("conversion did not begin after start");
  a_done_gives_code: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RULE8]
    (tif.busy && tif.enable && adc_done_i) |=> (tif.valid && tif.code == $past(adc_code_i)))
    else $error("finished code not captured");

endmodule : bts_temp_seq

// ===== logic/bts_status_regs.sv
// Register bank for the self-test pattern low byte, self-test PLL alarm,
// temperature monitor and latched per-channel lock-loss alarms.
// Assumes a byte-wide register port driven by the serial programming logic,
// with write and read strobes one cycle wide.
`timescale 1ns/100ps
module bts_status_regs #(
  parameter int CHANNELS = 4
) (
  input  wire logic                clock_i,
  input  wire logic                rstn_i,
  input  wire logic [7:0]          reg_addr_i,
  input  wire logic [7:0]          reg_wdata_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  output logic [7:0]               reg_rdata_o,
  input  wire logic [3:0]          pattern_top_nibble_i,
  input  wire logic [7:0]          pattern_mid_byte_i,
  output logic [19:0]              user_pattern_o,
  input  wire logic [7:0]          selftest_tx_control_i,
  input  wire logic                pll_softreset_i,
  input  wire logic                selftest_pll_unlocked_i,
  output logic                     pll_power_o,
  output logic                     pll_reset_o,
  output logic                     adc_power_o,
  output logic                     adc_start_o,
  input  wire logic [3:0]          adc_code_i,
  input  wire logic                adc_done_i,
  output logic                     temp_high_alarm_o,
  output logic                     temp_high_warn_o,
  output logic                     temp_low_warn_o,
  output logic                     temp_low_alarm_o,
  input  wire logic                global_clear_i,
  input  wire logic [CHANNELS-1:0] channel_unlocked_i,
  output logic [CHANNELS-1:0]      channel_unlocked_latched_o
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]          pattern_byte_low_q, pattern_byte_low_d;
  logic [6:0]          tx_alarm_rw_q,      tx_alarm_rw_d;
  logic [3:0]          temp_ctrl_q,        temp_ctrl_d;
  logic [3:0]          temp_value_q,       temp_value_d;
  logic [3:0]          lock_upper_q,       lock_upper_d;
  logic [CHANNELS-1:0] lock_latched_q,     lock_latched_d;
  logic [CHANNELS-1:0] unlocked_prev_q;
  logic [7:0]          rdata_q,            rdata_d;
  logic                tx_enable;
  logic                selftest_pll_unlocked;
  logic                strobe_rise;
  logic                wr_temp_ctrl;

  bts_temp_if tif ();

  bts_temp_seq u_seq (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .tif         (tif.seq),
    .adc_power_o (adc_power_o),
    .adc_start_o (adc_start_o),
    .adc_code_i  (adc_code_i),
    .adc_done_i  (adc_done_i)
  );

  // ----------------------------------------------------------------
  // Self-test transmitter
  // ----------------------------------------------------------------
  // Pattern assembly and PLL gating by the transmitter enable
  assign user_pattern_o = {pattern_top_nibble_i, pattern_mid_byte_i, pattern_byte_low_q}; // [RULE1] [RULE2]
  assign tx_enable      = selftest_tx_control_i[bts_pkg::TX_ENABLE_BIT];
  assign pll_power_o    = tx_enable; // [RULE4]
  assign pll_reset_o    = tx_enable && pll_softreset_i; // [RULE4]
  assign selftest_pll_unlocked = tx_enable && selftest_pll_unlocked_i; // [RULE3]

  // ----------------------------------------------------------------
  // Temperature monitor
  // ----------------------------------------------------------------
  // A write that moves the strobe from 0 to 1 requests a conversion
  assign wr_temp_ctrl = reg_wr_i && (reg_addr_i == bts_pkg::ADDR_TEMP_CTRL);
  assign strobe_rise  = wr_temp_ctrl && reg_wdata_i[bts_pkg::TEMP_STROBE_BIT]
                        && !temp_ctrl_q[bts_pkg::TEMP_STROBE_BIT]; // [RULE6] [RULE7]
  assign tif.start    = strobe_rise;
  assign tif.enable   = temp_ctrl_q[bts_pkg::TEMP_EN_BIT]; // [RULE5]

  // Band decode of the stored code
  assign temp_high_alarm_o = (temp_value_q >= bts_pkg::TEMP_HIGH_ALARM_MIN); // [RULE9]
  assign temp_high_warn_o  = (temp_value_q == bts_pkg::TEMP_HIGH_WARN); // [RULE9]
  assign temp_low_warn_o   = (temp_value_q == bts_pkg::TEMP_LOW_WARN); // [RULE9]
  assign temp_low_alarm_o  = (temp_value_q <= bts_pkg::TEMP_LOW_ALARM_MAX); // [RULE9]

  // ----------------------------------------------------------------
  // Lock-loss alarms
  // ----------------------------------------------------------------
  // Per channel: clear reloads present alarms, otherwise rising edges set
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_lock
      always_comb begin
        if (global_clear_i) begin
          lock_latched_d[ch] = channel_unlocked_i[ch]; // [RULE11]
        end else begin
          lock_latched_d[ch] = lock_latched_q[ch]
                               || (channel_unlocked_i[ch] && !unlocked_prev_q[ch]); // [RULE11] [RULE12]
        end
      end
    end
  endgenerate

  assign channel_unlocked_latched_o = lock_latched_q; // [RULE10]

  // ----------------------------------------------------------------
  // Register writes and reads
  // ----------------------------------------------------------------
  // Write decode, result capture and read mux
  always_comb begin
    pattern_byte_low_d = pattern_byte_low_q;
    tx_alarm_rw_d      = tx_alarm_rw_q;
    temp_ctrl_d        = temp_ctrl_q;
    lock_upper_d       = lock_upper_q;
    temp_value_d       = temp_value_q;
    rdata_d            = rdata_q;
    if (tif.valid) begin
      temp_value_d = tif.code; // [RULE8]
    end
    if (reg_wr_i) begin
      if (reg_addr_i == bts_pkg::ADDR_PATTERN_LOW) begin
        pattern_byte_low_d = reg_wdata_i; // [RULE1]
      end else if (reg_addr_i == bts_pkg::ADDR_TX_ALARM) begin
        tx_alarm_rw_d = reg_wdata_i[6:0];
      end else if (reg_addr_i == bts_pkg::ADDR_TEMP_CTRL) begin
        temp_ctrl_d = reg_wdata_i[3:0]; // [RULE5]
      end else if (reg_addr_i == bts_pkg::ADDR_LOCK_ALARM) begin
        lock_upper_d = reg_wdata_i[7:4];
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == bts_pkg::ADDR_PATTERN_LOW) begin
        rdata_d = pattern_byte_low_q;
      end else if (reg_addr_i == bts_pkg::ADDR_TX_ALARM) begin
        rdata_d = {selftest_pll_unlocked, tx_alarm_rw_q}; // [RULE3]
      end else if (reg_addr_i == bts_pkg::ADDR_TEMP_CTRL) begin
        rdata_d = {4'h0, temp_ctrl_q};
      end else if (reg_addr_i == bts_pkg::ADDR_TEMP_VALUE) begin
        rdata_d = {4'h0, temp_value_q}; // [RULE8]
      end else if (reg_addr_i == bts_pkg::ADDR_LOCK_ALARM) begin
        rdata_d = {lock_upper_q, 4'(lock_latched_q)}; // [RULE10]
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  // Register bank flip-flops
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pattern_byte_low_q <= bts_pkg::RST_PATTERN_LOW; // [RULE1]
      tx_alarm_rw_q      <= bts_pkg::RST_TX_ALARM;
      temp_ctrl_q        <= bts_pkg::RST_TEMP_CTRL; // [RULE5]
      temp_value_q       <= bts_pkg::RST_TEMP_CODE;
      lock_upper_q       <= bts_pkg::RST_LOCK_UPPER;
      lock_latched_q     <= '0;
      unlocked_prev_q    <= '0;
      rdata_q            <= 8'h00;
    end else begin
      pattern_byte_low_q <= pattern_byte_low_d;
      tx_alarm_rw_q      <= tx_alarm_rw_d;
      temp_ctrl_q        <= temp_ctrl_d;
      temp_value_q       <= temp_value_d;
      lock_upper_q       <= lock_upper_d;
      lock_latched_q     <= lock_latched_d;
      unlocked_prev_q    <= channel_unlocked_i;
      rdata_q            <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_clear_now;
    global_clear_i;
  endsequence

  sequence s_no_clear_2;
    !global_clear_i [*2];
  endsequence

  a_pattern_write: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RULE1]
    (reg_wr_i && reg_addr_i == 8'h1D) |=> (user_pattern_o[7:0] == $past(reg_wdata_i)))
    else $error("pattern low byte not written");
  a_pattern_join: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RULE2]
    user_pattern_o[19:8] == {pattern_top_nibble_i, pattern_mid_byte_i})
    else $error("upper pattern bits misplaced");
  a_pll_lol_read: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RULE3]
    (reg_rd_i && reg_addr_i == 8'h1F) |=>
      (reg_rdata_o[bts_pkg::TX_UNLOCK_BIT] == ($past(selftest_pll_unlocked_i) && $past(tx_enable))))
    else $error("PLL lock-loss bit wrong");
  a_pll_gated: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RULE4]
    !tx_enable |-> (!pll_power_o && !pll_reset_o))
    else $error("PLL active while transmitter disabled");
  a_monitor_off: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RULE5]
    !temp_ctrl_q[1] |-> (!adc_power_o && !adc_start_o))
    else $error("monitor active while disabled");
  a_strobe_starts: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RULE6]
    (strobe_rise && temp_ctrl_q[1] && !tif.busy) |-> adc_start_o)
    else $error("strobe edge did not start conversion");
  a_value_read: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RULE8]
    (tif.valid ##1 (reg_rd_i && reg_addr_i == 8'h21 && !tif.valid)) |=>
      (reg_rdata_o == {4'h0, $past(tif.code, 2)}))
    else $error("temperature value not returned");
  a_band_alarm: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RULE9]
    (temp_value_q == 4'hC || temp_value_q == 4'hB) |-> (temp_high_alarm_o && !temp_high_warn_o))
    else $error("high alarm band wrong");
  a_lock_read: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RULE10]
    (reg_rd_i && reg_addr_i == 8'h30) |=> (reg_rdata_o[3:0] == $past(lock_latched_q[3:0])))
    else $error("lock alarm read wrong");
  a_clear_reload: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RULE11]
    s_clear_now |=> (lock_latched_q == $past(channel_unlocked_i)))
    else $error("clear did not reload present alarms");
  a_latch_holds: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RULE12]
    (lock_latched_q[0] && !global_clear_i) ##1 s_no_clear_2 |-> lock_latched_q[0])
    else $error("latched alarm dropped without clear");

endmodule : bts_status_regs

// ===== verification/bts_tb.sv
// Self-checking testbench for the status register bank.
// Assumes the bank's hand-over contract: one-cycle strobes, read data one edge later.
`timescale 1ns/100ps
module testbench;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic        clock_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [7:0]  reg_rdata_o;
  logic [3:0]  pattern_top_nibble_i = 4'h0;
  logic [7:0]  pattern_mid_byte_i = 8'h00;
  logic [19:0] user_pattern_o;
  logic [7:0]  selftest_tx_control_i = 8'h00;
  logic        pll_softreset_i = 1'b0;
  logic        selftest_pll_unlocked_i = 1'b0;
  logic        pll_power_o;
  logic        pll_reset_o;
  logic        adc_power_o;
  logic        adc_start_o;
  logic [3:0]  adc_code_i = 4'h0;
  logic        adc_done_i = 1'b0;
  logic        temp_high_alarm_o;
  logic        temp_high_warn_o;
  logic        temp_low_warn_o;
  logic        temp_low_alarm_o;
  logic        global_clear_i = 1'b0;
  logic [3:0]  channel_unlocked_i = 4'h0;
  logic [3:0]  channel_unlocked_latched_o;
  int          miscompares = 0;
  int          n_checks = 0;
  logic        rd_pend;
  logic [7:0]  exp_q[$];

  bts_status_regs #(.CHANNELS(4)) i_dut (
    .clock_i(clock_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .pattern_top_nibble_i(pattern_top_nibble_i), .pattern_mid_byte_i(pattern_mid_byte_i),
    .user_pattern_o(user_pattern_o), .selftest_tx_control_i(selftest_tx_control_i),
    .pll_softreset_i(pll_softreset_i), .selftest_pll_unlocked_i(selftest_pll_unlocked_i),
    .pll_power_o(pll_power_o), .pll_reset_o(pll_reset_o), .adc_power_o(adc_power_o),
    .adc_start_o(adc_start_o), .adc_code_i(adc_code_i), .adc_done_i(adc_done_i),
    .temp_high_alarm_o(temp_high_alarm_o), .temp_high_warn_o(temp_high_warn_o),
    .temp_low_warn_o(temp_low_warn_o), .temp_low_alarm_o(temp_low_alarm_o),
    .global_clear_i(global_clear_i), .channel_unlocked_i(channel_unlocked_i),
    .channel_unlocked_latched_o(channel_unlocked_latched_o)
  );

  // ----------------------------------------------------------------
  // Clock, tasks and read-data monitor
  // ----------------------------------------------------------------
  // 200 MHz clock
  initial begin
    forever #2.5 clock_i = ~clock_i;
  end

  task automatic test_done;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Step to just after the next rising edge
  task automatic tick;
    @(posedge clock_i);
    #1;
  endtask : tick

  // Register write, then one idle edge; reports the start pulse seen in the write cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic st);
    reg_addr_i  = a;
    reg_wdata_i = d;
    reg_wr_i    = 1'b1;
    #1 st = adc_start_o;
    tick();
    reg_wr_i = 1'b0;
    tick();
  endtask : wr

  // Register read, then one idle edge; the expected byte is queued for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr_i = a;
    reg_rd_i   = 1'b1;
    tick();
    reg_rd_i = 1'b0;
    tick();
  endtask : rd

  // One strobed conversion returning code c
  task automatic conv(input logic [3:0] c);
    logic st;
    wr(bts_pkg::ADDR_TEMP_CTRL, 8'h03, st);
    chk("adc_start_o", 20'h00001, {19'h0, st});
    tick();
    adc_code_i = c;
    adc_done_i = 1'b1;
    tick();
    adc_done_i = 1'b0;
    adc_code_i = ~c;
    tick();
    tick();
    wr(bts_pkg::ADDR_TEMP_CTRL, 8'h02, st);
    chk("adc_start_o", 20'h00000, {19'h0, st});
  endtask : conv

  // Read data is settled by the falling edge after the read edge
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) rd_pend <= 1'b0;
    else rd_pend <= reg_rd_i;
  end
  always @(negedge clock_i) begin
    if (rd_pend) begin
      if (exp_q.size() == 0) chk("read queue", 20'h00001, 20'h00000);
      else chk("reg_rdata_o", {12'h000, exp_q.pop_front()}, {12'h000, reg_rdata_o});
    end
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clock_i);
    miscompares++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic [7:0] s7;
    logic [3:0] r;
    logic [3:0] t;
    logic       st;
    logic       u;
    void'($urandom(92753));
    pattern_top_nibble_i = 4'($urandom);
    pattern_mid_byte_i   = 8'($urandom);
    repeat (5) @(posedge clock_i);
    #1 rstn_i = 1'b1;
    // Reset values
    chk("user_pattern_o", {pattern_top_nibble_i, pattern_mid_byte_i, 8'hCC}, user_pattern_o);
    chk("low alarm at reset", 20'h00001, {19'h0, temp_low_alarm_o});
    chk("adc_power_o", 20'h00000, {19'h0, adc_power_o});
    rd(bts_pkg::ADDR_PATTERN_LOW, 8'hCC);
    rd(bts_pkg::ADDR_TEMP_CTRL, 8'h00);
    rd(bts_pkg::ADDR_LOCK_ALARM, 8'h00);
    rd(8'h55, 8'h00);
    // Pattern byte and full pattern assembly
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      pattern_top_nibble_i = 4'($urandom);
      pattern_mid_byte_i   = 8'($urandom);
      wr(bts_pkg::ADDR_PATTERN_LOW, d, st);
      chk("user_pattern_o", {pattern_top_nibble_i, pattern_mid_byte_i, d}, user_pattern_o);
      rd(bts_pkg::ADDR_PATTERN_LOW, d);
    end
    // PLL enable, soft reset and loss-of-lock report
    s7 = 8'($urandom);
    wr(bts_pkg::ADDR_TX_ALARM, s7, st);
    for (int i = 0; i < 8; i++) begin
      u = 1'(i >> 2);
      selftest_tx_control_i = {6'($urandom), i[0], 1'($urandom)};
      pll_softreset_i = i[1];
      selftest_pll_unlocked_i = u;
      if (i[0]) rd(bts_pkg::ADDR_TX_ALARM, {u, s7[6:0]});
      else tick();
      chk("pll_power_o", {19'h0, i[0]}, {19'h0, pll_power_o});
      chk("pll_reset_o", {19'h0, i[0] & i[1]}, {19'h0, pll_reset_o});
    end
    // Strobe while disabled starts nothing
    wr(bts_pkg::ADDR_TEMP_CTRL, 8'h01, st);
    chk("adc_start_o", 20'h00000, {19'h0, st});
    wr(bts_pkg::ADDR_TEMP_CTRL, 8'h00, st);
    wr(bts_pkg::ADDR_TEMP_CTRL, 8'h02, st);
    chk("adc_power_o", 20'h00001, {19'h0, adc_power_o});
    rd(bts_pkg::ADDR_TEMP_CTRL, 8'h02);
    // Codes 0 to 12 and their band flags
    for (int c = 0; c <= 12; c++) begin
      conv(4'(c));
      rd(bts_pkg::ADDR_TEMP_VALUE, 8'(c));
      chk("temp bands", {16'h0, c >= 11, c == 10, c == 2, c <= 1},
          {16'h0, temp_high_alarm_o, temp_high_warn_o, temp_low_warn_o, temp_low_alarm_o});
    end
    // Strobe held at 1 across a second write starts nothing
    wr(bts_pkg::ADDR_TEMP_CTRL, 8'h03, st);
    chk("adc_start_o", 20'h00001, {19'h0, st});
    wr(bts_pkg::ADDR_TEMP_CTRL, 8'h03, st);
    chk("adc_start_o", 20'h00000, {19'h0, st});
    // Disabling aborts the conversion in flight and keeps the old code
    wr(bts_pkg::ADDR_TEMP_CTRL, 8'h00, st);
    rd(bts_pkg::ADDR_TEMP_VALUE, 8'h0C);
    wr(bts_pkg::ADDR_TEMP_CTRL, 8'h02, st);
    wr(bts_pkg::ADDR_TEMP_CTRL, 8'h03, st);
    chk("adc_start_o", 20'h00001, {19'h0, st});
    wr(bts_pkg::ADDR_TEMP_CTRL, 8'h00, st);
    // Latched lock-loss alarms
    wr(bts_pkg::ADDR_LOCK_ALARM, 8'hA5, st);
    r = 4'($urandom) | 4'h1;
    channel_unlocked_i = r;
    tick();
    chk("latched", {16'h0, r}, {16'h0, channel_unlocked_latched_o});
    channel_unlocked_i = 4'h0;
    tick();
    tick();
    chk("latched", {16'h0, r}, {16'h0, channel_unlocked_latched_o});
    rd(bts_pkg::ADDR_LOCK_ALARM, {4'hA, r});
    t = 4'($urandom);
    channel_unlocked_i = t;
    global_clear_i = 1'b1;
    tick();
    chk("latched", {16'h0, t}, {16'h0, channel_unlocked_latched_o});
    global_clear_i = 1'b0;
    channel_unlocked_i = 4'h0;
    tick();
    channel_unlocked_i = 4'h8;
    tick();
    chk("latched", {16'h0, t | 4'h8}, {16'h0, channel_unlocked_latched_o});
    global_clear_i = 1'b1;
    channel_unlocked_i = 4'h0;
    tick();
    chk("latched", 20'h00000, {16'h0, channel_unlocked_latched_o});
    global_clear_i = 1'b0;
    tick();
    tick();
    chk("read queue empty", 20'h00000, 20'(exp_q.size()));
    test_done();
  end
endmodule : testbench
